// *** hdl/rrsc_pkg.sv ***
// rrsc_pkg: constants for the remote radio serial control block
// assumes: 20 MHz core clock, 12 ns link clock, plain register port
//
// Notes on behaviour
// - settings for two remote radios leave on one serial data pin, each bit with a clock pulse.
// - each radio carries three and a half BCD frequency digits plus an offset bit.
// - each radio has a power bit in the stream for switching its supply.
// - the stream holds a five-bit tone code and a tone enable bit.
// - the stream holds three band select bits set by software commands.
// - the stream holds a seven-bit antenna direction field.
// - a full burst goes out after reset, on scheduler change and on user command, about 1 ms long.
// - bits 40 to 47 are shifted out last so they land in the first external register.
// - radio 1 frequency sits in bits 32 to 45, so two external registers capture it.
// - the tone field sits in bits 10 to 15, so one external register captures it.
// - carrier inputs and key outputs of ports 1 and 2 have a selectable polarity.
// - key outputs of ports 3 and 4 are always active low.
// - each of four link ports is off, receive only, or receive and transmit.
package rrsc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RADIO1 = 8'h04;
  localparam logic [7:0] ADDR_RADIO2 = 8'h08;
  localparam logic [7:0] ADDR_TONE   = 8'h0c;
  localparam logic [7:0] ADDR_LINK   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ctrl bits
  localparam int CTRL_USER_BIT  = 0;
  localparam int CTRL_SCHED_BIT = 1;
  // link register fields
  localparam int LINK_KEY_LSB  = 8;
  localparam int LINK_POL_LSB  = 12;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CD_LSB   = 4;
  localparam int STAT_KEY_LSB  = 8;
  // ----------------------------------------
  // stream layout
  // ----------------------------------------
  localparam int BURST_BITS     = 48;
  localparam int STR_RADIO1_LSB = 32;
  localparam int STR_RADIO2_LSB = 16;
  localparam int STR_TONE_LSB   = 8;
  // ----------------------------------------
  // port modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    RRSC_MODE_OFF  = 2'h0,
    RRSC_MODE_RX   = 2'h1,
    RRSC_MODE_RXTX = 2'h2
  } rrsc_mode_t;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int BURST_TIME_US  = 1000;
  localparam int LINK_PERIOD_PS = 12000;
  localparam int HALF_BIT_CYC   =
    (BURST_TIME_US * 1000 * 1000) / (BURST_BITS * 2 * LINK_PERIOD_PS);
endpackage : rrsc_pkg

// *** hdl/rrsc_xfer_if.sv ***
// rrsc_xfer_if: burst word handover from core to link domain
// assumes: word stable while req and ack differ
`timescale 1ns/100ps
interface rrsc_xfer_if;
  logic        req_tgl;
  logic        ack_tgl;
  logic [47:0] word;
  modport core (output req_tgl, output word, input ack_tgl);
  modport link (input req_tgl, input word, output ack_tgl);
endinterface : rrsc_xfer_if

// *** hdl/rrsc_shifter.sv ***
// rrsc_shifter: serial burst shifter on the link clock
// assumes: reset already synchronised to link_clk_in
`timescale 1ns/100ps
module rrsc_shifter #(
  parameter int HALF_CYC = rrsc_pkg::HALF_BIT_CYC
) (
  // clock and reset
  input  wire logic  link_clk_in,
  input  wire logic  link_rst_n_in,
  // handover
  rrsc_xfer_if.link  xfer,
  // serial pins
  output logic       ser_data_out,
  output logic       ser_clk_out
);
  typedef enum logic [1:0] {
    RRSC_SH_IDLE = 2'b00,
    RRSC_SH_LOW  = 2'b01,
    RRSC_SH_HIGH = 2'b11
  } rrsc_sh_t;

  rrsc_sh_t    state_reg;
  logic [2:0]  req_sync_reg;
  logic [47:0] shift_reg;
  logic [5:0]  bit_reg;
  logic [15:0] tmr_reg;
  logic        ack_reg;
  logic        tmr_done;

  assign tmr_done     = (tmr_reg == 16'h0000);
  assign xfer.ack_tgl = ack_reg;

  // ----------------------------------------
  // request synchroniser
  // ----------------------------------------
  always_ff @(posedge link_clk_in or negedge link_rst_n_in)
  begin
    if (!link_rst_n_in)
      req_sync_reg <= 3'h0;
    else
      req_sync_reg <= {req_sync_reg[1:0], xfer.req_tgl};
  end

  // ----------------------------------------
  // shift sequencer
  // ----------------------------------------
  always_ff @(posedge link_clk_in or negedge link_rst_n_in)
  begin
    if (!link_rst_n_in)
    begin
      state_reg    <= RRSC_SH_IDLE;
      shift_reg    <= 48'h0;
      bit_reg      <= 6'h00;
      tmr_reg      <= 16'h0000;
      ack_reg      <= 1'b0;
      ser_data_out <= 1'b0;
      ser_clk_out  <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        RRSC_SH_IDLE:
        begin
          ser_clk_out <= 1'b0;
          if (req_sync_reg[2] != req_sync_reg[1])
          begin
            shift_reg    <= {1'b0, xfer.word[47:1]};
            ser_data_out <= xfer.word[0];
            bit_reg      <= 6'h00;
            tmr_reg      <= 16'(HALF_CYC - 1);
            state_reg    <= RRSC_SH_LOW;
          end
        end
        RRSC_SH_LOW:
        begin
          if (tmr_done)
          begin
            ser_clk_out <= 1'b1;
            tmr_reg     <= 16'(HALF_CYC - 1);
            state_reg   <= RRSC_SH_HIGH;
          end
          else
            tmr_reg <= tmr_reg - 16'h0001;
        end
        RRSC_SH_HIGH:
        begin
          if (tmr_done)
          begin
            ser_clk_out <= 1'b0;
            tmr_reg     <= 16'(HALF_CYC - 1);
            if (bit_reg == 6'(rrsc_pkg::BURST_BITS - 1))
            begin
              ack_reg   <= ~ack_reg;
              state_reg <= RRSC_SH_IDLE;
            end
            else
            begin
              ser_data_out <= shift_reg[0];
              shift_reg    <= {1'b0, shift_reg[47:1]};
              bit_reg      <= bit_reg + 6'h01;
              state_reg    <= RRSC_SH_LOW;
            end
          end
          else
            tmr_reg <= tmr_reg - 16'h0001;
        end
        default:
          state_reg <= RRSC_SH_IDLE;
      endcase
    end
  end
endmodule : rrsc_shifter

// *** hdl/rrsc_top.sv ***
// rrsc_top: remote radio serial control and link port keying
// assumes: core clock 20 MHz, separate link clock for the serial pins,
// pins for carrier detect arrive asynchronously
`timescale 1ns/100ps
module rrsc_top #(
  parameter int HALF_CYC = rrsc_pkg::HALF_BIT_CYC
) (
  // clocks and reset
  input  wire logic        core_clk_in,
  input  wire logic        link_clk_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // link ports
  input  wire logic [3:0]  carrier_detect_input_in,
  output logic      [3:0]  tx_key_out,
  // serial chain
  output logic             remote_serial_data_out,
  output logic             remote_serial_clock_out
);
  rrsc_xfer_if xfer ();

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] core_rst_reg;
  logic [1:0] link_rst_reg;
  logic       rst_n;
  logic       link_rst_n;

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      core_rst_reg <= 2'h0;
    else
      core_rst_reg <= {core_rst_reg[0], 1'b1};
  end

  always_ff @(posedge link_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      link_rst_reg <= 2'h0;
    else
      link_rst_reg <= {link_rst_reg[0], 1'b1};
  end

  assign rst_n      = core_rst_reg[1];
  assign link_rst_n = link_rst_reg[1];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] rrsc_radio_field(input logic [15:0] r);
    // freq bcd 13:0, offset 14, power 15
    rrsc_radio_field = {r[15], r[14], r[13:0]};
  endfunction : rrsc_radio_field

  function automatic logic rrsc_active(input logic lvl, input logic high_true);
    rrsc_active = high_true ? lvl : ~lvl;
  endfunction : rrsc_active

  localparam logic [1:0] RRSC_MODE_RX_C   = 2'(rrsc_pkg::RRSC_MODE_RX);
  localparam logic [1:0] RRSC_MODE_RXTX_C = 2'(rrsc_pkg::RRSC_MODE_RXTX);

  // port receiving: rx only or rx and tx, mode 3 counts as off
  function automatic logic rrsc_port_rx(input logic [1:0] m);
    rrsc_port_rx = (m == RRSC_MODE_RX_C) || (m == RRSC_MODE_RXTX_C);
  endfunction : rrsc_port_rx

  // port allowed to key its transmitter
  function automatic logic rrsc_port_tx(input logic [1:0] m);
    rrsc_port_tx = (m == RRSC_MODE_RXTX_C);
  endfunction : rrsc_port_tx

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] radio1_reg;
  logic [15:0] radio2_reg;
  logic [15:0] tone_reg;
  logic [15:0] link_reg;
  logic        wr_ctrl;
  logic        wr_radio1;
  logic        wr_radio2;
  logic        wr_tone;
  logic        wr_link;

  assign wr_ctrl   = reg_wr_in && (reg_addr_in == rrsc_pkg::ADDR_CTRL);
  assign wr_radio1 = reg_wr_in && (reg_addr_in == rrsc_pkg::ADDR_RADIO1);
  assign wr_radio2 = reg_wr_in && (reg_addr_in == rrsc_pkg::ADDR_RADIO2);
  assign wr_tone   = reg_wr_in && (reg_addr_in == rrsc_pkg::ADDR_TONE);
  assign wr_link   = reg_wr_in && (reg_addr_in == rrsc_pkg::ADDR_LINK);

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      radio1_reg <= 16'h0000;
      radio2_reg <= 16'h0000;
      tone_reg   <= 16'h0000;
    end
    else
    begin
      if (wr_radio1)
        radio1_reg <= reg_wdata_in[15:0];
      if (wr_radio2)
        radio2_reg <= reg_wdata_in[15:0];
      if (wr_tone)
        tone_reg <= reg_wdata_in[15:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      link_reg <= 16'h0000;
    else if (wr_link)
      link_reg <= reg_wdata_in[15:0];
  end

  // ----------------------------------------
  // stream word
  // ----------------------------------------
  logic [47:0] stream_word;

  always_comb
  begin
    stream_word = 48'h0;
    stream_word[rrsc_pkg::STR_RADIO1_LSB +: 16] = rrsc_radio_field(radio1_reg);
    stream_word[rrsc_pkg::STR_RADIO2_LSB +: 16] = rrsc_radio_field(radio2_reg);
    stream_word[rrsc_pkg::STR_TONE_LSB +: 8]    = {tone_reg[5], tone_reg[4:0], 2'h0};
    stream_word[9:7] = tone_reg[8:6];
    stream_word[6:0] = tone_reg[15:9];
    stream_word[15]  = tone_reg[5];
    stream_word[14:10] = tone_reg[4:0];
  end

  // ----------------------------------------
  // burst launch
  // ----------------------------------------
  logic        pend_reg;
  logic        req_reg;
  logic [47:0] word_reg;
  logic [1:0]  ack_sync_reg;
  logic        busy;
  logic        trigger;

  assign trigger = wr_ctrl && (reg_wdata_in[rrsc_pkg::CTRL_USER_BIT] ||
                               reg_wdata_in[rrsc_pkg::CTRL_SCHED_BIT]);
  assign busy    = (req_reg != ack_sync_reg[1]);

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ack_sync_reg <= 2'h0;
    else
      ack_sync_reg <= {ack_sync_reg[0], xfer.ack_tgl};
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      pend_reg <= 1'b1;
    else if (trigger)
      pend_reg <= 1'b1;
    else if (!busy)
      pend_reg <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_reg  <= 1'b0;
      word_reg <= 48'h0;
    end
    else if (pend_reg && !busy)
    begin
      word_reg <= stream_word;
      req_reg  <= ~req_reg;
    end
  end

  assign xfer.req_tgl = req_reg;
  assign xfer.word    = word_reg;

  rrsc_shifter #(
    .HALF_CYC (HALF_CYC)
  ) u_shifter (
    .link_clk_in   (link_clk_in),
    .link_rst_n_in (link_rst_n),
    .xfer          (xfer),
    .ser_data_out  (remote_serial_data_out),
    .ser_clk_out   (remote_serial_clock_out)
  );

  // ----------------------------------------
  // carrier detect
  // ----------------------------------------
  logic [3:0] cd_meta_reg;
  logic [3:0] cd_sync_reg;
  logic [3:0] cd_act_reg;

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cd_meta_reg <= 4'h0;
      cd_sync_reg <= 4'h0;
    end
    else
    begin
      cd_meta_reg <= carrier_detect_input_in;
      cd_sync_reg <= cd_meta_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cd_act_reg <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        logic on;
        logic high_true;
        on        = rrsc_port_rx(link_reg[2*i +: 2]);
        high_true = (i < 2) ? link_reg[rrsc_pkg::LINK_POL_LSB + i] : 1'b1;
        cd_act_reg[i] <= on && rrsc_active(cd_sync_reg[i], high_true);
      end
    end
  end

  // ----------------------------------------
  // transmit keying
  // ----------------------------------------
  logic [3:0] key_act;
  logic [3:0] key_pin_reg;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      key_act[i] = rrsc_port_tx(link_reg[2*i +: 2]) &&
                   link_reg[rrsc_pkg::LINK_KEY_LSB + i];
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      key_pin_reg <= 4'hf;
    else
    begin
      key_pin_reg[0] <= link_reg[rrsc_pkg::LINK_POL_LSB + 2] ? key_act[0] : ~key_act[0];
      key_pin_reg[1] <= link_reg[rrsc_pkg::LINK_POL_LSB + 3] ? key_act[1] : ~key_act[1];
      key_pin_reg[2] <= ~key_act[2];
      key_pin_reg[3] <= ~key_act[3];
    end
  end

  assign tx_key_out = key_pin_reg;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] rdata_reg;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (reg_addr_in)
      rrsc_pkg::ADDR_RADIO1: rd_mux[15:0] = radio1_reg;
      rrsc_pkg::ADDR_RADIO2: rd_mux[15:0] = radio2_reg;
      rrsc_pkg::ADDR_TONE:   rd_mux[15:0] = tone_reg;
      rrsc_pkg::ADDR_LINK:   rd_mux[15:0] = link_reg;
      rrsc_pkg::ADDR_STATUS:
      begin
        rd_mux[rrsc_pkg::STAT_BUSY_BIT]     = busy || pend_reg;
        rd_mux[rrsc_pkg::STAT_CD_LSB +: 4]  = cd_act_reg;
        rd_mux[rrsc_pkg::STAT_KEY_LSB +: 4] = key_act;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0;
    else if (reg_rd_in)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= 32'h0;
  end

  assign reg_rdata_out = rdata_reg;
endmodule : rrsc_top

// *** hdl/rrsc_dummy_unused.sv ***
`timescale 1ns/100ps

// *** testbench/rrsc_chain_model.sv ***
// chain model: external 8-bit shift register chain on the serial pins
// assumes: data taken on the rising serial clock edge
`timescale 1ns/100ps
module rrsc_chain_model (
  // serial pins
  input  wire logic        sclk_in,
  input  wire logic        sdata_in,
  // captured state
  output logic      [47:0] word_out,
  output logic      [15:0] pulse_cnt_out
);
  // ----
  // six stages, the first one is word_out[47:40]
  // ----
  initial
  begin
    word_out = 48'h0;
    pulse_cnt_out = 16'h0;
  end
  always @(posedge sclk_in)
  begin
    word_out <= {sdata_in, word_out[47:1]};
    pulse_cnt_out <= pulse_cnt_out + 16'h1;
  end
endmodule : rrsc_chain_model

// *** testbench/rrsc_top_asserts.sv ***
// checker: serial timing and key pin behaviour of rrsc_top
// assumes: bound into rrsc_top, both clocks running
`timescale 1ns/100ps
module rrsc_top_asserts #(
  parameter int HALF_CYC = 4
) (
  // clocks and reset
  input wire logic        core_clk_in,
  input wire logic        link_clk_in,
  input wire logic        reset_n_in,
  // register port
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // pins
  input wire logic [3:0]  carrier_detect_input_in,
  input wire logic [3:0]  tx_key_out,
  input wire logic        remote_serial_data_out,
  input wire logic        remote_serial_clock_out
);
  logic [15:0] hi_cnt_reg;
  logic [15:0] lo_cnt_reg;
  logic        link_wr_reg;
  logic        lwr;
  logic        sck;
  logic [31:0] wd;
  assign lwr = reg_wr_in && (reg_addr_in == rrsc_pkg::ADDR_LINK);
  assign sck = remote_serial_clock_out;
  assign wd = reg_wdata_in;
  always_ff @(posedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in) hi_cnt_reg <= 16'h0;
    else hi_cnt_reg <= sck ? hi_cnt_reg + 16'h1 : 16'h0;
  always_ff @(posedge link_clk_in or negedge reset_n_in)
    if (!reset_n_in) lo_cnt_reg <= 16'h0;
    else lo_cnt_reg <= sck ? 16'h0 : lo_cnt_reg + 16'(lo_cnt_reg != 16'hffff);
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in) link_wr_reg <= 1'b0;
    else link_wr_reg <= lwr;
  // ----
  // assertions
  // ----
  AST_DATA_ON_LOW: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    $changed(remote_serial_data_out) |-> !sck) else $error("data moved with clock high");
  AST_HIGH_LEN: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    $fell(sck) |-> hi_cnt_reg == HALF_CYC) else $error("clock high phase length wrong");
  AST_LOW_LEN: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    $rose(sck) |-> lo_cnt_reg >= HALF_CYC) else $error("clock low phase too short");
  AST_BURST_START: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    reg_wr_in && reg_addr_in == rrsc_pkg::ADDR_CTRL && wd[1:0] != 2'h0 |-> ##[1:120] sck)
    else $error("no burst after trigger");
  AST_KEY_HOLD: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $changed(tx_key_out) |-> $past(link_wr_reg)) else $error("key pins moved without write");
  AST_KEY1_POL: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    lwr && wd[1:0] == 2'h2 && wd[8] == wd[14] |-> ##2 tx_key_out[0])
    else $error("port 1 key level");
  AST_KEY2_POL: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    lwr && wd[3:2] == 2'h2 && wd[9] != wd[15] |-> ##2 !tx_key_out[1])
    else $error("port 2 key level");
  AST_KEY3_LOW: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    lwr && wd[5:4] == 2'h2 && wd[10] |-> ##2 !tx_key_out[2]) else $error("port 3 key not low");
  AST_KEY4_IDLE: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    lwr && wd[7:6] != 2'h2 |-> ##2 tx_key_out[3]) else $error("port 4 keyed while not rxtx");
  COV_PULSE: cover property (@(posedge link_clk_in) $rose(sck));
  COV_KEY3: cover property (@(posedge core_clk_in) lwr && wd[5:4] == 2'h2 && wd[10]);
  COV_TRIG: cover property (@(posedge core_clk_in) reg_wr_in && reg_addr_in == 8'h00);
endmodule : rrsc_top_asserts
bind rrsc_top rrsc_top_asserts #(.HALF_CYC(HALF_CYC)) rrsc_top_asserts_inst (
  .core_clk_in(core_clk_in), .link_clk_in(link_clk_in), .reset_n_in(reset_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .carrier_detect_input_in(carrier_detect_input_in), .tx_key_out(tx_key_out),
  .remote_serial_data_out(remote_serial_data_out),
  .remote_serial_clock_out(remote_serial_clock_out));

// *** testbench/test_rrsc_top.sv ***
// testbench: register traffic, serial bursts, link port pins
// assumes: rrsc_top with HALF_CYC 4, chain model on the serial pins
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); n_errors++; end end
module test_rrsc_top;
  typedef struct packed {
    logic [15:0] r1;
    logic [15:0] r2;
    logic [15:0] tone;
    logic [47:0] word;
  } rrsc_row_t;
  rrsc_row_t   rows [4] = '{'{16'hd234, 16'h2567, 16'h5575, 48'hd234_2567_d6aa},
                            '{16'h0001, 16'h8000, 16'h001f, 48'h0001_8000_7c00},
                            '{16'h0000, 16'h0000, 16'hffe0, 48'h0000_0000_83ff},
                            '{16'h4999, 16'h5999, 16'h0000, 48'h4999_5999_0000}};
  logic [19:0] lrows [5] = '{20'h0102e, 20'hc5aa9, 20'h4f55e, 20'h0ffff, 20'h8aa05};
  logic [23:0] crows [3] = '{24'h105557, 24'h1055a8, 24'h0000f0};
  logic        core_clk, link_clk, reset_n, wr, rd, sdata, sclk;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  cd, key;
  logic [47:0] word;
  logic [15:0] cnt, base;
  int          n_errors = 0;
  int          n_tests = 0;
  rrsc_top #(.HALF_CYC(4)) rrsc_top_inst (
    .core_clk_in(core_clk), .link_clk_in(link_clk), .reset_n_in(reset_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .carrier_detect_input_in(cd), .tx_key_out(key),
    .remote_serial_data_out(sdata), .remote_serial_clock_out(sclk));
  rrsc_chain_model rrsc_chain_model_inst (
    .sclk_in(sclk), .sdata_in(sdata), .word_out(word), .pulse_cnt_out(cnt));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #2;
    forever #6 link_clk = ~link_clk;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    rdv = rdata;
  endtask : rd_reg
  task automatic wait_cnt(input logic [15:0] t);
    int i;
    i = 0;
    while (cnt !== t && i < 3000)
    begin
      @(posedge core_clk);
      i++;
    end
  endtask : wait_cnt
  task automatic print_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    #400000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    reset_n = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    cd = 4'h0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_cnt(16'h30);
    `CHK("reset burst pulses", 16'h30, cnt)
    foreach (rows[i])
    begin
      base = cnt;
      wr_reg(rrsc_pkg::ADDR_RADIO1, {16'h0, rows[i].r1});
      wr_reg(rrsc_pkg::ADDR_RADIO2, {16'h0, rows[i].r2});
      wr_reg(rrsc_pkg::ADDR_TONE, {16'h0, rows[i].tone});
      wr_reg(rrsc_pkg::ADDR_CTRL, i[0] ? 32'h2 : 32'h1);
      wait_cnt(base + 16'h30);
      `CHK("burst pulses", base + 16'h30, cnt)
      `CHK("stream word", rows[i].word, word)
      rd_reg(rrsc_pkg::ADDR_RADIO1);
      `CHK("radio1 readback", {16'h0, rows[i].r1}, rdv)
    end
    base = cnt;
    wr_reg(rrsc_pkg::ADDR_CTRL, 32'h1);
    rd_reg(rrsc_pkg::ADDR_STATUS);
    `CHK("busy flag", 1'b1, rdv[0])
    wr_reg(rrsc_pkg::ADDR_RADIO1, 32'h1111);
    wr_reg(rrsc_pkg::ADDR_CTRL, 32'h2);
    wait_cnt(base + 16'h30);
    `CHK("first word", rows[3].word, word)
    wait_cnt(base + 16'h60);
    `CHK("pending word", {16'h1111, rows[3].word[31:0]}, word)
    rd_reg(8'h20);
    `CHK("unmapped read", 32'h0, rdv)
    foreach (lrows[i])
    begin
      wr_reg(rrsc_pkg::ADDR_LINK, {16'h0, lrows[i][19:4]});
      @(posedge core_clk);
      #1;
      `CHK("key pins", lrows[i][3:0], key)
    end
    foreach (crows[i])
    begin
      wr_reg(rrsc_pkg::ADDR_LINK, {16'h0, crows[i][23:8]});
      cd <= crows[i][7:4];
      repeat (4) @(posedge core_clk);
      rd_reg(rrsc_pkg::ADDR_STATUS);
      `CHK("carrier status", crows[i][3:0], rdv[7:4])
    end
    wr_reg(rrsc_pkg::ADDR_CTRL, 32'h1);
    repeat (30) @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("key in reset", 4'hf, key)
    `CHK("serial clock in reset", 1'b0, sclk)
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    base = cnt;
    wait_cnt(base + 16'h30);
    `CHK("burst after reset", base + 16'h30, cnt)
    print_verdict;
  end
endmodule : test_rrsc_top
